// ===== common/rcs_pkg.sv
// Constants and types shared by the redundant reference clock switch.
// Assumes a single core clock; all pin levels except the divider reset are sampled in that domain.
package rcs_pkg;

  // Differential output pair, complement always opposite the true leg
  typedef struct packed {
    logic pos;
    logic neg;
  } rcs_pair_type;

  // Active reference source, one-hot
  typedef enum logic [1:0] {
    RCS_SRC_ZERO = 2'b01,
    RCS_SRC_ONE = 2'b10
  } rcs_src_type;

  // Pin sampler slots
  localparam int IN_REF0 = 0;
  localparam int IN_REF1 = 1;
  localparam int IN_FB = 2;
  localparam int IN_SEL = 3;
  localparam int IN_OVR = 4;
  localparam int IN_PLLEN = 5;
  localparam int IN_CLR = 6;
  localparam int IN_COUNT = 7;

  // Reset levels follow the pin pulls: clear and loop enable pulled up
  localparam logic [IN_COUNT-1:0] SYNC_RST = 7'h60;

  // Feedback rising edges without a reference edge that mark a stuck input
  localparam logic [1:0] FB_EDGES_TO_FAIL = 2'h2;

  localparam int BASE_PAIRS = 2;
  localparam int DOUBLE_PAIRS = 3;
  localparam int PERIOD_W = 16;

  localparam rcs_pair_type PAIR_LOW = 2'h1;
  localparam rcs_src_type SRC_RST = RCS_SRC_ZERO;
  localparam logic FLAG_RST = 1'h0;

endpackage : rcs_pkg

// ===== core/rcs_switch.sv
// Redundant reference clock switch: pin sampling, stuck-input monitor,
// automatic source switching, and regenerated base and double rate outputs.
// Assumes core_clk is far faster than the references so edges are resolved.
//
// Summary of operation
// - Watch both references; constant high or low for a full period means failed.
// - Judge each reference failure against rising edges of the feedback clock.
// - On failure latch that input's own fail flag high.
// - Failed active primary moves to the secondary if the secondary is good.
// - Fail flags are active high and stay high until the clear input.
// - Active source indicator is 0 for input zero, 1 for input one.
// - Flag-clear input low clears both fail flags.
// - Flag-clear low also returns active source to the source-select request.
// - Flag-clear acts once per assertion, not continuously while held low.
// - Source-select 0 requests input zero, 1 requests input one.
// - Auto-switch-disable high stops failures from moving the active source.
// - Loop-use enable low routes the selected reference around the loop to the double rate outputs.
// - Divider reset low clears output dividers and forces every clock output low.
// - Divider reset acts asynchronously, without waiting for a clock edge.
// - Two pairs at reference rate, three at double rate, phase aligned.
`timescale 1ns/100ps
`default_nettype none

module rcs_switch #(
  parameter int PERIOD_W = rcs_pkg::PERIOD_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ref_input_zero,
  input wire logic ref_input_one,
  input wire logic feedback_clock_in,
  input wire logic source_select,
  input wire logic auto_switch_disable,
  input wire logic loop_enable,
  input wire logic flag_clear_n,
  input wire logic divider_reset_n,
  output var rcs_pkg::rcs_pair_type [rcs_pkg::BASE_PAIRS-1:0] base_rate_outputs,
  output var rcs_pkg::rcs_pair_type [rcs_pkg::DOUBLE_PAIRS-1:0] double_rate_outputs,
  output logic input_zero_fail_flag,
  output logic input_one_fail_flag,
  output logic active_source
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, level accepted once stages two and three agree

  logic [rcs_pkg::IN_COUNT-1:0] pins;
  logic [rcs_pkg::IN_COUNT-1:0] s1;
  logic [rcs_pkg::IN_COUNT-1:0] s2;
  logic [rcs_pkg::IN_COUNT-1:0] s3;
  logic [rcs_pkg::IN_COUNT-1:0] filt;
  logic [rcs_pkg::IN_COUNT-1:0] filt_d;
  logic [rcs_pkg::IN_COUNT-1:0] next_filt;

  assign pins = {flag_clear_n, loop_enable, auto_switch_disable, source_select,
                 feedback_clock_in, ref_input_one, ref_input_zero};

  always_comb begin
    for (int i = 0; i < rcs_pkg::IN_COUNT; i++) begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1 <= rcs_pkg::SYNC_RST;
      s2 <= rcs_pkg::SYNC_RST;
      s3 <= rcs_pkg::SYNC_RST;
      filt <= rcs_pkg::SYNC_RST;
      filt_d <= rcs_pkg::SYNC_RST;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      filt_d <= filt;
    end
  end

  logic ref0_edge;
  logic ref1_edge;
  logic fb_rise;
  logic clr_pulse;
  logic req_one;

  assign ref0_edge = filt[rcs_pkg::IN_REF0] ^ filt_d[rcs_pkg::IN_REF0];
  assign ref1_edge = filt[rcs_pkg::IN_REF1] ^ filt_d[rcs_pkg::IN_REF1];
  assign fb_rise = filt[rcs_pkg::IN_FB] & ~filt_d[rcs_pkg::IN_FB];
  // Falling edge only, so a held-low clear acts once
  assign clr_pulse = ~filt[rcs_pkg::IN_CLR] & filt_d[rcs_pkg::IN_CLR];
  assign req_one = filt[rcs_pkg::IN_SEL];

  ////////////////////////////////////////////////////////////////////////////
  // Stuck-input monitor, fail flags and active source

  logic [1:0] fb_cnt0;
  logic [1:0] fb_cnt1;
  logic [1:0] next_fb_cnt0;
  logic [1:0] next_fb_cnt1;
  logic next_flag0;
  logic next_flag1;
  rcs_pkg::rcs_src_type src;
  rcs_pkg::rcs_src_type next_src;
  logic fail0;
  logic fail1;

  always_comb begin
    next_fb_cnt0 = fb_cnt0;
    next_fb_cnt1 = fb_cnt1;
    fail0 = 1'b0;
    fail1 = 1'b0;
    // Limitation: a stopped feedback clock hides a stuck reference
    if (ref0_edge) begin
      next_fb_cnt0 = 2'h0;
    end else if (fb_rise && fb_cnt0 != rcs_pkg::FB_EDGES_TO_FAIL) begin
      next_fb_cnt0 = fb_cnt0 + 2'h1;
      fail0 = (next_fb_cnt0 == rcs_pkg::FB_EDGES_TO_FAIL);
    end
    if (ref1_edge) begin
      next_fb_cnt1 = 2'h0;
    end else if (fb_rise && fb_cnt1 != rcs_pkg::FB_EDGES_TO_FAIL) begin
      next_fb_cnt1 = fb_cnt1 + 2'h1;
      fail1 = (next_fb_cnt1 == rcs_pkg::FB_EDGES_TO_FAIL);
    end
    // Set wins over a clear in the same cycle
    next_flag0 = fail0 | (input_zero_fail_flag & ~clr_pulse);
    next_flag1 = fail1 | (input_one_fail_flag & ~clr_pulse);
    next_src = src;
    if (filt[rcs_pkg::IN_OVR] || clr_pulse) begin
      next_src = req_one ? rcs_pkg::RCS_SRC_ONE : rcs_pkg::RCS_SRC_ZERO;
    end else begin
      case (src)
        rcs_pkg::RCS_SRC_ZERO: begin
          if (next_flag0 && !next_flag1) begin
            next_src = rcs_pkg::RCS_SRC_ONE;
          end
        end
        rcs_pkg::RCS_SRC_ONE: begin
          if (next_flag1 && !next_flag0) begin
            next_src = rcs_pkg::RCS_SRC_ZERO;
          end
        end
        default: begin
          next_src = rcs_pkg::SRC_RST;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fb_cnt0 <= 2'h0;
      fb_cnt1 <= 2'h0;
      input_zero_fail_flag <= rcs_pkg::FLAG_RST;
      input_one_fail_flag <= rcs_pkg::FLAG_RST;
      src <= rcs_pkg::SRC_RST;
      active_source <= 1'h0;
    end else begin
      fb_cnt0 <= next_fb_cnt0;
      fb_cnt1 <= next_fb_cnt1;
      input_zero_fail_flag <= next_flag0;
      input_one_fail_flag <= next_flag1;
      src <= next_src;
      active_source <= (next_src == rcs_pkg::RCS_SRC_ONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output dividers: base follows the chosen reference, double adds a mid toggle

  logic sel_lvl;
  logic sel_edge;
  logic [PERIOD_W-1:0] half_cnt;
  logic [PERIOD_W-1:0] half_len;
  logic mid_pending;
  logic dbl_lvl;
  logic [PERIOD_W-1:0] next_half_cnt;
  logic [PERIOD_W-1:0] next_half_len;
  logic next_mid_pending;
  logic next_dbl_lvl;
  logic base_lvl;
  logic next_base_lvl;
  logic [PERIOD_W-1:0] free_cnt;
  logic [PERIOD_W-1:0] next_free_cnt;
  rcs_pkg::rcs_pair_type [rcs_pkg::BASE_PAIRS-1:0] next_base;
  rcs_pkg::rcs_pair_type [rcs_pkg::DOUBLE_PAIRS-1:0] next_double;

  assign sel_lvl = (src == rcs_pkg::RCS_SRC_ONE) ? filt[rcs_pkg::IN_REF1] : filt[rcs_pkg::IN_REF0];
  assign sel_edge = (src == rcs_pkg::RCS_SRC_ONE) ? ref1_edge : ref0_edge;

  always_comb begin
    next_half_cnt = half_cnt;
    next_half_len = half_len;
    next_mid_pending = mid_pending;
    next_dbl_lvl = dbl_lvl;
    next_base_lvl = base_lvl;
    next_free_cnt = free_cnt;
    if (sel_edge) begin
      // Aligned with every reference edge, half period measured in core cycles
      next_half_len = half_cnt;
      next_half_cnt = {{(PERIOD_W-1){1'b0}}, 1'b1};
      next_free_cnt = {{(PERIOD_W-1){1'b0}}, 1'b1};
      next_base_lvl = sel_lvl;
      next_mid_pending = 1'b1;
      next_dbl_lvl = ~dbl_lvl;
    end else begin
      if (half_cnt != {PERIOD_W{1'b1}}) begin
        next_half_cnt = half_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
      if (free_cnt != {PERIOD_W{1'b1}}) begin
        next_free_cnt = free_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
      // Coast on the last period so feedback survives a stuck reference
      if (half_len != '0 && free_cnt > half_len) begin
        next_free_cnt = {{(PERIOD_W-1){1'b0}}, 1'b1};
        next_base_lvl = ~base_lvl;
        next_mid_pending = 1'b1;
        next_dbl_lvl = ~dbl_lvl;
      end else if (mid_pending && free_cnt == (half_len >> 1)) begin
        next_mid_pending = 1'b0;
        next_dbl_lvl = ~dbl_lvl;
      end
    end
    for (int i = 0; i < rcs_pkg::BASE_PAIRS; i++) begin
      next_base[i].pos = next_base_lvl;
      next_base[i].neg = ~next_base_lvl;
    end
    for (int i = 0; i < rcs_pkg::DOUBLE_PAIRS; i++) begin
      // Bypass passes the reference itself, no doubling
      next_double[i].pos = filt[rcs_pkg::IN_PLLEN] ? next_dbl_lvl : sel_lvl;
      next_double[i].neg = filt[rcs_pkg::IN_PLLEN] ? ~next_dbl_lvl : ~sel_lvl;
    end
  end

  always_ff @(posedge core_clk or negedge divider_reset_n) begin
    if (!divider_reset_n) begin
      half_cnt <= '0;
      half_len <= '0;
      mid_pending <= 1'b0;
      dbl_lvl <= 1'b0;
      base_lvl <= 1'b0;
      free_cnt <= '0;
      base_rate_outputs <= {rcs_pkg::BASE_PAIRS{rcs_pkg::PAIR_LOW}};
      double_rate_outputs <= {rcs_pkg::DOUBLE_PAIRS{rcs_pkg::PAIR_LOW}};
    end else if (sys_rst) begin
      half_cnt <= '0;
      half_len <= '0;
      mid_pending <= 1'b0;
      dbl_lvl <= 1'b0;
      base_lvl <= 1'b0;
      free_cnt <= '0;
      base_rate_outputs <= {rcs_pkg::BASE_PAIRS{rcs_pkg::PAIR_LOW}};
      double_rate_outputs <= {rcs_pkg::DOUBLE_PAIRS{rcs_pkg::PAIR_LOW}};
    end else begin
      half_cnt <= next_half_cnt;
      half_len <= next_half_len;
      mid_pending <= next_mid_pending;
      dbl_lvl <= next_dbl_lvl;
      base_lvl <= next_base_lvl;
      free_cnt <= next_free_cnt;
      base_rate_outputs <= next_base;
      double_rate_outputs <= next_double;
    end
  end

endmodule : rcs_switch

`default_nettype wire

// ===== tb/rcs_switch_chk.sv
// Checker bound to the clock switch top ports.
// Assumes pin changes reach flags and source four edges later.
`timescale 1ns/100ps
`default_nettype none
module rcs_switch_chk #(
  parameter int PERIOD_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic source_select,
  input wire logic auto_switch_disable,
  input wire logic flag_clear_n,
  input wire logic divider_reset_n,
  input wire rcs_pkg::rcs_pair_type [rcs_pkg::BASE_PAIRS-1:0] base_rate_outputs,
  input wire rcs_pkg::rcs_pair_type [rcs_pkg::DOUBLE_PAIRS-1:0] double_rate_outputs,
  input wire logic input_zero_fail_flag,
  input wire logic input_one_fail_flag,
  input wire logic active_source
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////
  flag0_sticky_a: assert property ($fell(input_zero_fail_flag) |-> !$past(flag_clear_n, 4))
    else $error("flag zero dropped");
  flag1_sticky_a: assert property ($fell(input_one_fail_flag) |-> !$past(flag_clear_n, 4))
    else $error("flag one dropped");
  outputs_low_a: assert property (!divider_reset_n |->
    {base_rate_outputs, double_rate_outputs} == {5{rcs_pkg::PAIR_LOW}})
    else $error("outputs not low");
  pair_compl_a: assert property (base_rate_outputs[1].neg != base_rate_outputs[1].pos)
    else $error("pair legs equal");
  sel_one_a: assert property ((auto_switch_disable && source_select) [*6] |-> active_source)
    else $error("source not one");
  sel_zero_a: assert property ((auto_switch_disable && !source_select) [*6] |-> !active_source)
    else $error("source not zero");
  both_hold_a: assert property (input_zero_fail_flag && input_one_fail_flag
    && $past(input_zero_fail_flag) && $past(input_one_fail_flag) && !auto_switch_disable
    |-> $stable(active_source))
    else $error("source moved");
  failover_a: assert property ($rose(input_zero_fail_flag) && !$past(active_source)
    && !input_one_fail_flag && !auto_switch_disable |-> active_source)
    else $error("no failover");
endmodule : rcs_switch_chk
bind rcs_switch rcs_switch_chk #(.PERIOD_W(PERIOD_W)) u_chk (.*);
`default_nettype wire

// ===== tb/rcs_ref_src.sv
// Model of the two board reference sources.
// Assumes the bench halts a source to make it stick at its level.
`timescale 1ns/100ps
`default_nettype none
module rcs_ref_src #(
  parameter int HALF = 200
) (
  input wire logic halt_zero,
  input wire logic halt_one,
  output logic ref_zero,
  output logic ref_one
);
  //////////////////////////////////////////////////////////////////
  initial begin
    ref_zero = 1'h0;
    forever #HALF if (!halt_zero) ref_zero = ~ref_zero;
  end
  // Odd half period and offset so edges of the two line up only every 42600 ns, first at 2200
  initial begin
    ref_one = 1'h0;
    #70;
    forever #(HALF + 13) if (!halt_one) ref_one = ~ref_one;
  end
endmodule : rcs_ref_src
`default_nettype wire

// ===== tb/rcs_switch_bench.sv
// Self-checking bench for the clock switch with modelled flags and source.
// Assumes feedback comes from the first base-rate pair.
`timescale 1ns/100ps
`default_nettype none
module rcs_switch_bench;
  logic core_clk, sys_rst, source_select, auto_switch_disable, loop_enable, flag_clear_n;
  logic divider_reset_n, ref_input_zero, ref_input_one, feedback_clock_in, halt_zero, halt_one;
  logic input_zero_fail_flag, input_one_fail_flag, active_source;
  rcs_pkg::rcs_pair_type [rcs_pkg::BASE_PAIRS-1:0] base_rate_outputs;
  rcs_pkg::rcs_pair_type [rcs_pkg::DOUBLE_PAIRS-1:0] double_rate_outputs;
  int fail_count = 0, total_checks = 0, seed = 15751, exp_f0 = 0, exp_f1 = 0, exp_act = 0;
  assign feedback_clock_in = base_rate_outputs[0].pos;
  rcs_switch #(.PERIOD_W(16)) u_dut (.*);
  rcs_ref_src u_src (.halt_zero(halt_zero), .halt_one(halt_one), .ref_zero(ref_input_zero),
    .ref_one(ref_input_one));
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  function automatic logic [2:0] now_state();
    return {input_zero_fail_flag, input_one_fail_flag, active_source};
  endfunction : now_state
  // Bounded wait for the model state; a miss ends the run
  task automatic expect_state(input int wait_max);
    logic [2:0] e;
    int n;
    e = {exp_f0[0], exp_f1[0], exp_act[0]};
    n = 0;
    while (now_state() !== e && n < wait_max) begin
      @(negedge core_clk);
      n++;
    end
    check_val(10'(now_state()), 10'(e));
    if (now_state() !== e) print_verdict();
  endtask : expect_state
  task automatic clear_to(input logic sel);
    source_select = sel;
    flag_clear_n = 1'h0;
    repeat (6) @(negedge core_clk);
    flag_clear_n = 1'h1;
    exp_f0 = 0;
    exp_f1 = 0;
    exp_act = sel;
  endtask : clear_to
  //////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'h1;
    source_select = 1'h0;
    auto_switch_disable = 1'h0;
    loop_enable = 1'h1;
    flag_clear_n = 1'h1;
    divider_reset_n = 1'h1;
    halt_zero = 1'h0;
    halt_one = 1'h0;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'h0;
    expect_state(0);
    auto_switch_disable = 1'h1;
    repeat (6) begin
      source_select = 1'($random(seed));
      loop_enable = 1'($random(seed));
      exp_act = source_select;
      repeat (6) @(negedge core_clk);
      expect_state(0);
    end
    loop_enable = 1'h1;
    source_select = 1'h0;
    auto_switch_disable = 1'h0;
    exp_act = 0;
    repeat (6) @(negedge core_clk);
    // Secondary dies: flag only, no switch
    halt_one = 1'h1;
    exp_f1 = 1;
    expect_state(200);
    halt_one = 1'h0;
    repeat (40) @(negedge core_clk);
    expect_state(0);
    source_select = 1'h1;
    flag_clear_n = 1'h0;
    exp_f1 = 0;
    exp_act = 1;
    expect_state(20);
    // Clear still held low must not wipe a new failure
    halt_zero = 1'h1;
    exp_f0 = 1;
    expect_state(200);
    repeat (40) @(negedge core_clk);
    expect_state(0);
    halt_zero = 1'h0;
    flag_clear_n = 1'h1;
    @(negedge core_clk);
    #5;
    divider_reset_n = 1'h0;
    #1;
    check_val({base_rate_outputs, double_rate_outputs}, {5{rcs_pkg::PAIR_LOW}});
    @(negedge core_clk);
    divider_reset_n = 1'h1;
    clear_to(1'h0);
    expect_state(20);
    repeat (40) @(negedge core_clk);
    halt_zero = 1'h1;
    exp_f0 = 1;
    exp_act = 1;
    expect_state(200);
    halt_one = 1'h1;
    exp_f1 = 1;
    expect_state(200);
    halt_zero = 1'h0;
    halt_one = 1'h0;
    auto_switch_disable = 1'h1;
    clear_to(1'h0);
    expect_state(20);
    repeat (40) @(negedge core_clk);
    halt_zero = 1'h1;
    exp_f0 = 1;
    expect_state(200);
    print_verdict();
  end
endmodule : rcs_switch_bench
`default_nettype wire
